/* File: hdl/tw_slave.sv */
// two-wire slave with clock stretching, status flags and wishbone registers
//
// Operation
// - write mode: hold clock low while shifter and receive holding are full
// - tx free clears when byte enters shifter, sets on ack or nack
// - transfer complete set on stop or restart with foreign address
// - clock wait flag follows the stretching itself
// - nack bit reads 1 for an unacknowledged byte, until status read or new match
// - slave read: nack bit set when master refuses a data byte
// - slave write: every received data byte is acknowledged
// - underrun flag bit 7, only without stretching, cleared on read
// - overrun flag bit 6, only without stretching, cleared on read
// - general call flag bit 5, cleared on status read
// - address matched flag bit 4, cleared by nack or stop
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module tw_slave
  import tw_slave_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // wishbone slave
  input  wire wb_req_type  wb_req,
  output logic             wb_ack,
  output logic [31:0]      wb_dat_o,
  // interrupt
  output logic             irq,
  // two-wire pins, oe_n low pulls the line low
  input  wire logic        scl_i,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_oe_n
);

  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;

  // two stages, then one history stage for edges
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      {scl_meta, scl_sync, scl_prev} <= 3'h7;
      {sda_meta, sda_sync, sda_prev} <= 3'h7;
    end
    else if (ce)
    begin
      {scl_meta, scl_sync, scl_prev} <= {scl_i, scl_meta, scl_sync};
      {sda_meta, sda_sync, sda_prev} <= {sda_i, sda_meta, sda_sync};
    end

  // line events
  wire scl_rise   = scl_sync & ~scl_prev;
  wire scl_fall   = ~scl_sync & scl_prev;
  wire start_cond = scl_sync & scl_prev & sda_prev & ~sda_sync;
  wire stop_cond  = scl_sync & scl_prev & ~sda_prev & sda_sync;

  ////////////////////////////////////////////////////////////////
  // state
  link_state_type     state_reg;
  logic [7:0]         shift_reg;
  logic [3:0]         cnt_reg;
  logic               sda_low_reg;
  logic               hold_reg;
  logic               read_mode_reg;
  logic               busy_reg;
  logic [7:0]         rhr_reg;
  logic [7:0]         thr_reg;
  logic               thr_valid_reg;
  logic               tx_free_reg;
  logic               rx_full_reg;
  logic               matched_reg;
  logic               gc_reg;
  logic               ovr_reg;
  logic               unr_reg;
  logic               nack_reg;
  logic               transfer_complete_flag_reg;
  logic [CTRL_W-1:0]  ctrl_reg;
  logic [FLAG_W-1:0]  mask_reg;
  logic [FLAG_W-1:0]  ev_reg;
  logic               ack_reg;
  logic [31:0]        dat_reg;

  ////////////////////////////////////////////////////////////////
  // control fields
  wire [6:0] own_slave_address = ctrl_reg[CTRL_ADDR_LSB +: 7];
  wire       stretch_off = ctrl_reg[CTRL_NOSTR];
  wire       gc_en       = ctrl_reg[CTRL_GC_EN];
  wire       slave_en    = ctrl_reg[CTRL_EN];

  // bus decode
  wire wb_take  = wb_req.cyc & wb_req.stb & ~ack_reg;
  wire wb_wr    = wb_take & wb_req.we;
  wire wb_rd    = wb_take & ~wb_req.we;
  wire hit_stat = wb_req.adr == OFS_STATUS;
  wire hit_ctrl = wb_req.adr == OFS_CTRL;
  wire hit_thr  = wb_req.adr == OFS_THR;
  wire hit_rhr  = wb_req.adr == OFS_RHR;
  wire hit_mask = wb_req.adr == OFS_IRQ_MASK;
  wire hit_ist  = wb_req.adr == OFS_IRQ_STAT;
  wire stat_rd  = wb_rd & hit_stat;
  wire rhr_rd   = wb_rd & hit_rhr;
  wire thr_wr   = wb_wr & hit_thr & wb_req.sel[0];
  wire [FLAG_W-1:0] wmask = {{2{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};

  ////////////////////////////////////////////////////////////////
  // address decisions
  wire cnt_full  = cnt_reg == BITS_PER_BYTE;
  wire addr_done = (state_reg == ST_ADDR) & scl_fall & cnt_full;
  wire own_hit   = shift_reg[7:1] == own_slave_address;
  wire gc_hit    = gc_en & (shift_reg == 8'h00);
  wire addr_hit  = own_hit | gc_hit;
  wire match_set = addr_done & addr_hit;
  wire gc_set    = addr_done & gc_hit;

  // write path: load receive holding or stretch
  wire wr_wait   = (state_reg == ST_WR_DATA) & cnt_full;
  wire rx_load   = wr_wait & (scl_fall | hold_reg) & (~rx_full_reg | stretch_off);
  wire hold_wr   = wr_wait & scl_fall & rx_full_reg & ~stretch_off;
  wire ovr_set   = rx_load & rx_full_reg;

  // read path: fetch next byte after address ack or master ack
  wire rd_point  = ((state_reg == ST_ADDR_ACK) & read_mode_reg)
                 | (state_reg == ST_RD_ACK);
  wire tx_need   = rd_point & (scl_fall | hold_reg);
  wire tx_load   = tx_need & thr_valid_reg;
  wire unr_set   = tx_need & ~thr_valid_reg & stretch_off;
  wire tx_go     = tx_load | unr_set;
  wire hold_rd   = tx_need & ~thr_valid_reg & ~stretch_off & ~hold_reg;
  wire [7:0] tx_byte = tx_load ? thr_reg : UNDERRUN_BYTE;

  // master answer to a byte we sent
  wire rd_ans    = (state_reg == ST_RD_ACK) & scl_rise;
  wire nack_set  = rd_ans & sda_sync;
  wire txfree_set = rd_ans;

  // end of sequence
  wire transfer_complete_flag_set = busy_reg & (stop_cond | (addr_done & ~addr_hit));

  ////////////////////////////////////////////////////////////////
  // link state machine
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      state_reg     <= ST_IDLE;
      shift_reg     <= 8'h00;
      cnt_reg       <= 4'h0;
      sda_low_reg   <= 1'b0;
      hold_reg      <= 1'b0;
      read_mode_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (stop_cond | start_cond | ~slave_en)
      begin
        state_reg   <= (start_cond & slave_en) ? ST_ADDR : ST_IDLE;
        cnt_reg     <= 4'h0;
        sda_low_reg <= 1'b0;
        hold_reg    <= 1'b0;
      end
      else
        case (state_reg)
          ST_ADDR:
            if (scl_rise & ~cnt_full)
            begin
              shift_reg <= {shift_reg[6:0], sda_sync};
              cnt_reg   <= cnt_reg + 4'h1;
            end
            else if (addr_done)
            begin
              state_reg     <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
              sda_low_reg   <= addr_hit;
              read_mode_reg <= shift_reg[0];
            end
          ST_ADDR_ACK, ST_RD_ACK:
            if (rd_ans & sda_sync)
              state_reg <= ST_WAIT;
            else if (tx_go)
            begin
              shift_reg   <= tx_byte;
              sda_low_reg <= ~tx_byte[7];
              cnt_reg     <= 4'h0;
              hold_reg    <= 1'b0;
              state_reg   <= ST_RD_DATA;
            end
            else if (hold_rd)
            begin
              hold_reg    <= 1'b1;
              sda_low_reg <= 1'b0;
            end
            else if (~read_mode_reg & scl_fall)
            begin
              sda_low_reg <= 1'b0;
              cnt_reg     <= 4'h0;
              state_reg   <= ST_WR_DATA;
            end
          ST_WR_DATA:
            if (scl_rise & ~cnt_full)
            begin
              shift_reg <= {shift_reg[6:0], sda_sync};
              cnt_reg   <= cnt_reg + 4'h1;
            end
            else if (rx_load)
            begin
              sda_low_reg <= 1'b1;
              hold_reg    <= 1'b0;
              state_reg   <= ST_WR_ACK;
            end
            else if (hold_wr)
              hold_reg <= 1'b1;
          ST_WR_ACK:
            if (scl_fall)
            begin
              sda_low_reg <= 1'b0;
              cnt_reg     <= 4'h0;
              state_reg   <= ST_WR_DATA;
            end
          ST_RD_DATA:
            if (scl_rise)
              cnt_reg <= cnt_reg + 4'h1;
            else if (scl_fall & cnt_full)
            begin
              sda_low_reg <= 1'b0;
              state_reg   <= ST_RD_ACK;
            end
            else if (scl_fall)
            begin
              shift_reg   <= {shift_reg[6:0], 1'b0};
              sda_low_reg <= ~shift_reg[6];
            end
          default:
            state_reg <= state_reg;
        endcase
    end

  ////////////////////////////////////////////////////////////////
  // holding registers
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      rhr_reg       <= 8'h00;
      thr_reg       <= 8'h00;
      thr_valid_reg <= 1'b0;
      rx_full_reg   <= 1'b0;
      tx_free_reg   <= TXFREE_RESET;
    end
    else if (ce)
    begin
      if (rx_load)
        rhr_reg <= shift_reg;
      if (thr_wr)
        thr_reg <= wb_req.dat[7:0];
      thr_valid_reg <= thr_wr | (thr_valid_reg & ~tx_load);
      rx_full_reg   <= rx_load | (rx_full_reg & ~rhr_rd);
      tx_free_reg   <= txfree_set | (tx_free_reg & ~tx_load);
    end

  ////////////////////////////////////////////////////////////////
  // status flags, set wins over clear
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      busy_reg    <= 1'b0;
      matched_reg <= 1'b0;
      gc_reg      <= 1'b0;
      ovr_reg     <= 1'b0;
      unr_reg     <= 1'b0;
      nack_reg    <= 1'b0;
      transfer_complete_flag_reg  <= 1'b0;
    end
    else if (ce)
    begin
      busy_reg    <= match_set | (busy_reg & ~transfer_complete_flag_set);
      matched_reg <= match_set | (matched_reg & ~stop_cond & ~nack_set);
      gc_reg      <= gc_set | (gc_reg & ~stat_rd);
      ovr_reg     <= ovr_set | (ovr_reg & ~stat_rd);
      unr_reg     <= unr_set | (unr_reg & ~stat_rd);
      nack_reg    <= nack_set | (nack_reg & ~stat_rd & ~match_set);
      transfer_complete_flag_reg  <= transfer_complete_flag_set | (transfer_complete_flag_reg & ~match_set);
    end

  // visible status word
  logic [FLAG_W-1:0] status_word;
  always_comb
  begin
    status_word             = '0;
    status_word[BIT_TRANSFER_COMPLETE_FLAG] = transfer_complete_flag_reg;
    status_word[BIT_RXFULL] = rx_full_reg;
    status_word[BIT_TXFREE] = tx_free_reg;
    status_word[BIT_RDMODE] = read_mode_reg;
    status_word[BIT_MATCH]  = matched_reg;
    status_word[BIT_GCALL]  = gc_reg;
    status_word[BIT_OVR]    = ovr_reg;
    status_word[BIT_UNR]    = unr_reg;
    status_word[BIT_NACK]   = nack_reg;
    status_word[BIT_WAIT]   = hold_reg;
  end

  // interrupt events in status layout
  logic [FLAG_W-1:0] ev_set;
  always_comb
  begin
    ev_set             = '0;
    ev_set[BIT_TRANSFER_COMPLETE_FLAG] = transfer_complete_flag_set;
    ev_set[BIT_RXFULL] = rx_load;
    ev_set[BIT_TXFREE] = txfree_set;
    ev_set[BIT_MATCH]  = match_set;
    ev_set[BIT_GCALL]  = gc_set;
    ev_set[BIT_OVR]    = ovr_set;
    ev_set[BIT_UNR]    = unr_set;
    ev_set[BIT_NACK]   = nack_set;
    ev_set[BIT_WAIT]   = hold_wr | hold_rd;
  end

  wire [FLAG_W-1:0] ev_clr = (wb_wr & hit_ist) ? (wb_req.dat[FLAG_W-1:0] & wmask) : '0;

  ////////////////////////////////////////////////////////////////
  // control, mask and interrupt registers
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= MASK_RESET;
      ev_reg   <= '0;
    end
    else if (ce)
    begin
      if (wb_wr & hit_ctrl & wb_req.sel[0])
        ctrl_reg[7:0] <= wb_req.dat[7:0];
      if (wb_wr & hit_ctrl & wb_req.sel[1])
        ctrl_reg[CTRL_W-1:8] <= wb_req.dat[CTRL_W-1:8];
      if (wb_wr & hit_mask)
        mask_reg <= (mask_reg & ~wmask) | (wb_req.dat[FLAG_W-1:0] & wmask);
      ev_reg <= ev_set | (ev_reg & ~ev_clr);
    end

  // read data selection
  wire [31:0] rd_mux =
      hit_stat ? {22'h00_0000, status_word} :
      hit_ctrl ? {21'h00_0000, ctrl_reg} :
      hit_rhr  ? {24'h00_0000, rhr_reg} :
      hit_mask ? {22'h00_0000, mask_reg} :
      hit_ist  ? {22'h00_0000, ev_reg} : 32'h0000_0000;

  // bus answer one cycle after the request
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ack_reg <= wb_take;
      if (wb_rd)
        dat_reg <= rd_mux;
    end

  // outputs
  assign wb_ack   = ack_reg & wb_req.cyc & wb_req.stb;
  assign wb_dat_o = dat_reg;
  assign irq      = |(ev_reg & mask_reg);
  assign scl_oe_n = ~hold_reg;
  assign sda_oe_n = ~sda_low_reg;

  ////////////////////////////////////////////////////////////////
  // checks
  sequence wr_full_seq;
    wr_wait && scl_fall && rx_full_reg && !stretch_off;
  endsequence

  sequence rd_nack_seq;
    state_reg == ST_RD_ACK && scl_rise && sda_sync;
  endsequence

  stretch_start_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    wr_full_seq |=> hold_reg && !scl_oe_n)
    else $error("clock not held with both buffers full");

  stretch_end_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    hold_reg && wr_wait && !rx_full_reg && !start_cond && !stop_cond
    |=> !hold_reg && state_reg == ST_WR_ACK && !sda_oe_n)
    else $error("stretch not ended after holding read");

  txfree_move_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    tx_load |=> !tx_free_reg && !status_word[BIT_TXFREE])
    else $error("tx free not cleared on byte move");

  transfer_complete_flag_stop_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    stop_cond && busy_reg |=> transfer_complete_flag_reg && !busy_reg)
    else $error("transfer complete missing after stop");

  wait_flag_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    $rose(status_word[BIT_WAIT]) |-> $past(hold_wr || hold_rd))
    else $error("wait flag without stretch start");

  nack_seen_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    rd_nack_seq |=> nack_reg && tx_free_reg && !matched_reg && state_reg == ST_WAIT)
    else $error("master nack not recorded");

  ack_write_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    rx_load |=> !sda_oe_n && rx_full_reg && rhr_reg == $past(shift_reg))
    else $error("received byte not acknowledged");

  underrun_mode_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    $rose(unr_reg) |-> stretch_off)
    else $error("underrun while stretching enabled");

  overrun_mode_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    $rose(ovr_reg) |-> stretch_off)
    else $error("overrun while stretching enabled");

  match_stop_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    stop_cond |=> !matched_reg [*2])
    else $error("address match not cleared by stop");

  foreign_addr_a: assert property (@(posedge clk) disable iff (sys_rst || !ce)
    addr_done && !addr_hit |=> state_reg == ST_IDLE && sda_oe_n)
    else $error("foreign address answered");

endmodule // tw_slave
`default_nettype wire

/* File: hdl/tw_slave_pkg.sv */
// shared constants and types of the two-wire slave
package tw_slave_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_CTRL     = 8'h04;
  localparam logic [7:0] OFS_THR      = 8'h08;
  localparam logic [7:0] OFS_RHR      = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  // status bit positions
  localparam int BIT_TRANSFER_COMPLETE_FLAG = 0;
  localparam int BIT_RXFULL = 1;
  localparam int BIT_TXFREE = 2;
  localparam int BIT_RDMODE = 3;
  localparam int BIT_MATCH  = 4;
  localparam int BIT_GCALL  = 5;
  localparam int BIT_OVR    = 6;
  localparam int BIT_UNR    = 7;
  localparam int BIT_NACK   = 8;
  localparam int BIT_WAIT   = 9;
  localparam int FLAG_W     = 10;
  // control fields
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_NOSTR    = 8;
  localparam int CTRL_GC_EN    = 9;
  localparam int CTRL_EN       = 10;
  localparam int CTRL_W        = 11;
  // values after reset
  localparam logic [CTRL_W-1:0] CTRL_RESET   = 11'h000;
  localparam logic [FLAG_W-1:0] MASK_RESET   = 10'h000;
  localparam logic              TXFREE_RESET = 1'b1;
  localparam logic [7:0]        UNDERRUN_BYTE = 8'hFF;
  localparam logic [3:0]        BITS_PER_BYTE = 4'h8;
  // link states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_DATA,
    ST_WR_ACK, ST_RD_DATA, ST_RD_ACK, ST_WAIT
  } link_state_type;
  // classic wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_type;
endpackage

/* File: bench/tw_master_model.sv */
// behavioural two-wire bus master that waits out clock stretching
`timescale 1ns/100ps
`default_nettype none
module tw_master_model (
  // bench clock, each task but pulse starts on its falling edge
  input  wire logic clk,
  // line levels seen on the wire
  input  wire logic scl,
  input  wire logic sda,
  // open-drain drives, low pulls the line
  output logic      scl_oe_n,
  output logic      sda_oe_n
);
  localparam int QTR = 80;
  int stretch_ns;
  // lines released, clock stands still between frames
  initial
  begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
    stretch_ns = 0;
  end
  // one clock pulse: data set while low, sampled while high
  task automatic pulse(input logic b, output logic r);
    int n;
    n = 0;
    sda_oe_n = b;
    #QTR;
    scl_oe_n = 1'b1;
    #QTR;
    // a slave holding the clock low delays the high phase
    // polls keep to falling edges, away from the sampling edge
    while (scl !== 1'b1 && n < 4000)
    begin
      #(QTR / 2);
      n++;
    end
    stretch_ns += n * (QTR / 2);
    r = sda;
    #QTR;
    scl_oe_n = 1'b0;
    #QTR;
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    @(negedge clk);
    sda_oe_n = 1'b1;
    #QTR;
    scl_oe_n = 1'b1;
    #(2 * QTR);
    sda_oe_n = 1'b0;
    #QTR;
    scl_oe_n = 1'b0;
    #QTR;
  endtask
  // stop: data rises while clock high, then all released
  task automatic stop();
    @(negedge clk);
    sda_oe_n = 1'b0;
    #QTR;
    scl_oe_n = 1'b1;
    #QTR;
    sda_oe_n = 1'b1;
    #(2 * QTR);
  endtask
  // byte out msb first, acknowledge read back in ninth pulse
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    @(negedge clk);
    for (int i = 7; i >= 0; i--)
      pulse(d[i], r);
    pulse(1'b1, r);
    ack = ~r;
  endtask
  // byte in msb first, then own acknowledge or refusal
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    @(negedge clk);
    for (int i = 7; i >= 0; i--)
      pulse(1'b1, d[i]);
    pulse(nack, r);
  endtask
endmodule // tw_master_model
`default_nettype wire

/* File: bench/two_wire_slave_status_stretch_tb.sv */
// self-checking bench of the two-wire slave against a bus master model
`timescale 1ns/100ps
`default_nettype none
module two_wire_slave_status_stretch_tb;
  import tw_slave_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        clk;
  logic        sys_rst;
  logic        ce;
  wb_req_type  wb_req;
  logic        wb_ack;
  logic [31:0] wb_dat_o;
  logic        irq;
  logic        scl_oe_n;
  logic        sda_oe_n;
  logic        m_scl_oe_n;
  logic        m_sda_oe_n;
  wire         scl_w;
  wire         sda_w;
  int          mismatches;
  int          num_checks;
  logic [6:0]  own;
  logic [31:0] ctrl;
  logic [7:0]  d;
  logic        a;
  logic [7:0]  rx_q[$];
  ////////////////////////////////////////////////////////////////////////
  // open-drain wires with pull-up, clock
  assign scl_w = scl_oe_n & m_scl_oe_n;
  assign sda_w = sda_oe_n & m_sda_oe_n;
  always #20 clk = ~clk;
  tw_slave uut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .wb_req(wb_req), .wb_ack(wb_ack),
    .wb_dat_o(wb_dat_o), .irq(irq), .scl_i(scl_w), .scl_oe_n(scl_oe_n), .sda_i(sda_w),
    .sda_oe_n(sda_oe_n));
  tw_master_model m (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_oe_n(m_scl_oe_n),
    .sda_oe_n(m_sda_oe_n));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] f(input int b);
    return 32'h0000_0001 << b;
  endfunction
  // single compare of any result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // classic single wishbone cycle, ack and read data taken at a rising edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
    @(posedge clk);
    while (wb_ack !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    rd = wb_dat_o;
    wb_req <= '0;
    if (n >= 50)
      chk(32'h0000_0000, 32'h0000_0001, "bus answer");
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] v;
    wb(1'b1, adr, dat, v);
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] msk, input logic [31:0] exp,
                        input string what);
    logic [31:0] v;
    wb(1'b0, adr, 32'h0000_0000, v);
    chk(v & msk, exp, what);
  endtask
  // wait for the device to hold the clock, then see it stay held
  task automatic wait_stretch();
    int n;
    n = 0;
    while (scl_oe_n !== 1'b0 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    repeat (16) @(negedge clk);
    chk(32'(scl_oe_n), 32'h0000_0000, "clock held");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the fifteen bytes of traffic
  initial
  begin
    #2_000_000;
    mismatches++;
    test_done();
  end
  // main sequence
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    ce = 1'b1;
    wb_req = '0;
    mismatches = 0;
    num_checks = 0;
    void'($urandom(32'h672d_cd66));
    own = 7'($urandom_range(8, 119));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values and an unmapped place
    rd_chk(OFS_STATUS, ALL, f(BIT_TXFREE), "status reset");
    rd_chk(OFS_CTRL, ALL, 32'h0000_0000, "ctrl reset");
    rd_chk(OFS_IRQ_MASK, ALL, 32'h0000_0000, "mask reset");
    rd_chk(8'h18, ALL, 32'h0000_0000, "unmapped");
    ctrl = f(CTRL_EN) | f(CTRL_GC_EN) | 32'(own);
    wr(OFS_CTRL, ctrl);
    rd_chk(OFS_CTRL, ALL, ctrl, "ctrl");
    wr(OFS_IRQ_MASK, 32'h0000_03FF);
    // write transfer, second byte stretched until the first is drained
    m.start();
    m.wr_byte({own, 1'b0}, a);
    chk(32'(a), 32'h0000_0001, "own address");
    rd_chk(OFS_STATUS, f(BIT_MATCH), f(BIT_MATCH), "matched");
    repeat (2)
    begin
      d = 8'($urandom);
      rx_q.push_back(d);
      fork
        m.wr_byte(d, a);
        if (rx_q.size() > 1)
        begin
          wait_stretch();
          rd_chk(OFS_STATUS, f(BIT_WAIT), f(BIT_WAIT), "wait flag");
          rd_chk(OFS_RHR, 32'h0000_00FF, 32'(rx_q.pop_front()), "rhr");
        end
      join
      chk(32'(a), 32'h0000_0001, "data ack");
    end
    rd_chk(OFS_RHR, 32'h0000_00FF, 32'(rx_q.pop_front()), "rhr");
    m.stop();
    rd_chk(OFS_STATUS, f(BIT_TRANSFER_COMPLETE_FLAG) | f(BIT_MATCH) | f(BIT_WAIT), f(BIT_TRANSFER_COMPLETE_FLAG), "stop");
    // interrupt raised, masked and cleared
    chk(32'(irq), 32'h0000_0001, "irq set");
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000, "irq masked");
    wr(OFS_IRQ_MASK, 32'h0000_03FF);
    rd_chk(OFS_IRQ_STAT, f(BIT_TRANSFER_COMPLETE_FLAG), f(BIT_TRANSFER_COMPLETE_FLAG), "irq status");
    wr(OFS_IRQ_STAT, 32'h0000_03FF);
    chk(32'(irq), 32'h0000_0000, "irq cleared");
    // foreign address ignored, general call taken
    m.start();
    m.wr_byte({own ^ 7'h01, 1'b0}, a);
    chk(32'(a), 32'h0000_0000, "foreign address");
    m.stop();
    rd_chk(OFS_STATUS, f(BIT_MATCH), 32'h0000_0000, "no match");
    m.start();
    m.wr_byte(8'h00, a);
    chk(32'(a), 32'h0000_0001, "general call");
    m.stop();
    rd_chk(OFS_STATUS, f(BIT_GCALL), f(BIT_GCALL), "gcall set");
    rd_chk(OFS_STATUS, f(BIT_GCALL), 32'h0000_0000, "gcall cleared");
    // general call refused while its enable is off
    wr(OFS_CTRL, f(CTRL_EN) | 32'(own));
    m.start();
    m.wr_byte(8'h00, a);
    chk(32'(a), 32'h0000_0000, "gcall disabled");
    m.stop();
    rd_chk(OFS_STATUS, f(BIT_GCALL), 32'h0000_0000, "gcall disabled");
    wr(OFS_CTRL, ctrl);
    // read transfer, second byte stretched until refilled, then refused
    d = 8'($urandom);
    wr(OFS_THR, 32'(d));
    rd_chk(OFS_STATUS, f(BIT_TXFREE), f(BIT_TXFREE), "free before move");
    m.start();
    m.wr_byte({own, 1'b1}, a);
    rd_chk(OFS_STATUS, f(BIT_TXFREE) | f(BIT_RDMODE), f(BIT_RDMODE), "byte moved");
    m.rd_byte(1'b0, d);
    wait_stretch();
    rd_chk(OFS_STATUS, f(BIT_TXFREE) | f(BIT_WAIT) | f(BIT_NACK), f(BIT_TXFREE) | f(BIT_WAIT), "acked");
    ctrl[7:0] = 8'($urandom);
    wr(OFS_THR, {24'h0, ctrl[7:0]});
    m.rd_byte(1'b1, d);
    chk(32'(d), {24'h0, ctrl[7:0]}, "read byte");
    // no refill while the refusal is pending
    rd_chk(OFS_STATUS, f(BIT_NACK) | f(BIT_MATCH) | f(BIT_TXFREE),
           f(BIT_NACK) | f(BIT_TXFREE), "refused");
    m.stop();
    rd_chk(OFS_STATUS, f(BIT_TRANSFER_COMPLETE_FLAG), f(BIT_TRANSFER_COMPLETE_FLAG), "read done");
    // stretching off: underrun then overrun
    ctrl = f(CTRL_EN) | f(CTRL_GC_EN) | f(CTRL_NOSTR) | 32'(own);
    wr(OFS_CTRL, ctrl);
    m.start();
    m.wr_byte({own, 1'b1}, a);
    m.rd_byte(1'b1, d);
    chk(32'(d), 32'(UNDERRUN_BYTE), "underrun byte");
    m.stop();
    rd_chk(OFS_STATUS, f(BIT_UNR), f(BIT_UNR), "underrun");
    rd_chk(OFS_STATUS, f(BIT_UNR), 32'h0000_0000, "underrun read");
    m.start();
    m.wr_byte({own, 1'b0}, a);
    repeat (2)
    begin
      d = 8'($urandom);
      m.wr_byte(d, a);
      chk(32'(a), 32'h0000_0001, "no-stretch ack");
    end
    // repeated start with a foreign address ends the sequence
    m.start();
    m.wr_byte({own ^ 7'h01, 1'b0}, a);
    rd_chk(OFS_STATUS, f(BIT_TRANSFER_COMPLETE_FLAG) | f(BIT_OVR), f(BIT_TRANSFER_COMPLETE_FLAG) | f(BIT_OVR), "restart");
    m.stop();
    rd_chk(OFS_RHR, 32'h0000_00FF, 32'(d), "overwritten");
    rd_chk(OFS_STATUS, f(BIT_OVR), 32'h0000_0000, "overrun read");
    test_done();
  end
endmodule // two_wire_slave_status_stretch_tb
`default_nettype wire
